// ===== logic/fsi_defs.svh
// Offsets, field positions, reset values and timing counts
`ifndef FSI_DEFS_SVH
`define FSI_DEFS_SVH
// ==========================================
// Register byte addresses
`define FSI_A_IO_CFG 8'h00
`define FSI_A_MISC_CFG 8'h04
`define FSI_A_IRQ_EN 8'h08
`define FSI_A_STATUS 8'h0c
`define FSI_A_DIAG 8'h10
`define FSI_A_BAD_CODE 8'h14
`define FSI_A_OFC1 8'h18
`define FSI_A_OFC2 8'h1c
// ==========================================
// Field positions
`define FSI_IO_HD 0
`define FSI_IO_SLEW 1
`define FSI_IO_PINSEL 2
`define FSI_IO_BADEN 3
`define FSI_IO_G1OE 4
`define FSI_IO_G2OE 5
`define FSI_EN_LOFF 0
`define FSI_EN_RANGE 1
`define FSI_EN_FIFO 2
`define FSI_EN_CLK 3
`define FSI_EN_DEB_LO 4
`define FSI_EN_DEB_HI 5
// ==========================================
// Reset values
`define FSI_IO_CFG_RST 6'h00
`define FSI_IRQ_EN_RST 6'h00
`define FSI_OFC_RST 24'h000000
// ==========================================
// Timing
`define FSI_CLK_KHZ 25000
`define FSI_LOFF_LONG_US 15600
`define FSI_LOFF_SHORT_US 7800
`define FSI_FIFO_PULSE_NS 4000
`define FSI_LOFF_LONG_CYC (`FSI_LOFF_LONG_US * `FSI_CLK_KHZ / 1000)
`define FSI_LOFF_SHORT_CYC (`FSI_LOFF_SHORT_US * `FSI_CLK_KHZ / 1000)
`define FSI_FIFO_CYC ((`FSI_FIFO_PULSE_NS * `FSI_CLK_KHZ + 999999) / 1000000)
`define FSI_RANGE_TICKS 2
`define FSI_LIMIT_UA 500
`endif

// ===== logic/fsi_pkg.sv
// Types shared by the fault status unit
package fsi_pkg;
  typedef enum logic {CAL_IDLE, CAL_MEASURE} fsi_cal_state_t;
  typedef logic [1:0] fsi_resp_t;
endpackage : fsi_pkg

// ===== logic/fsi_pulse_stretch.sv
// Minimum-length pulse generator counting enable ticks
`timescale 1ns/1ns
module fsi_pulse_stretch #(
  parameter int CW = 20
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic trig_in,
  input wire logic tick_in,
  input wire logic [CW-1:0] load_in,
  output logic pulse_out
);
  logic [CW-1:0] cnt_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg <= '0;
    end else if (trig_in) begin
      cnt_reg <= load_in;
    end else if (tick_in && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  assign pulse_out = (cnt_reg != '0);
endmodule : fsi_pulse_stretch

// ===== logic/fsi_offset_sub.sv
// Offset correction subtractor for one channel
`timescale 1ns/1ns
module fsi_offset_sub #(
  parameter int W = 24
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic valid_in,
  input wire logic [W-1:0] raw_in,
  input wire logic [W-1:0] ofc_in,
  output logic [W-1:0] data_out,
  output logic valid_out
);
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_out <= '0;
      valid_out <= 1'b0;
    end else begin
      valid_out <= valid_in;
      if (valid_in) begin
        data_out <= raw_in - ofc_in;
      end
    end
  end
endmodule : fsi_offset_sub

// ===== logic/fsi_fault_status_unit.sv
// Fault status, short capture, interrupt routing and offset correction
// How it works
// R1: In high-drive mode, output pin shorts are detected and current limited to 500uA.
// R2: Only the first short is captured; software clears before a new capture.
// R3: Ground short sets ground flag; supply short sets supply flag.
// R4: Shared slew and high-drive bits govern pins; serial out has own drive bit.
// R5: Software picks slew, drive and serial-out bits by required output frequency.
// R6: Five interrupt sources routed to the selected general-purpose pin when enabled.
// R7: An interrupt drives the selected pin high.
// R8: Lead-off pulse lasts 15.6ms for debounce 2'b10, 7.8ms for 2'b01.
// R9: Each source reaches the pin only when its enable bit is set.
// R10: Range interrupt lasts at least one output data rate period.
// R11: FIFO interrupt lasts at least 4us.
// R12: Clock-missing interrupt holds until software clear or reset.
// R13: Bad command interrupt records first command, holds until status cleared.
// R14: Clock-missing diagnostic flag raised when external clock is absent.
// R15: Frame-miss flag raised when a frame is missed or overwritten.
// R16: Buffer error flag when FIFO disabled and read and write pointers differ.
// R17: Separate flags for command check error and data check error.
// R18: Positive and negative over-range flags per amplifier, plus initial-setting error.
// R19: Positive and negative lead-off flags for leg drive and both channels.
// R20: Calibration command measures offset and writes per-channel correction registers.
// R21: Stored correction is subtracted from conversion results before readout.
// R22: Correction registers are readable and writable by software.
// R23: Sticky flags clear on write-one; clearing drops the interrupt they hold.
`timescale 1ns/1ns
`include "fsi_defs.svh"
module fsi_fault_status_unit import fsi_pkg::*; #(
  parameter int LOFF_LONG_CYC = `FSI_LOFF_LONG_CYC,
  parameter int LOFF_SHORT_CYC = `FSI_LOFF_SHORT_CYC,
  parameter int DW = 24
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [4:0] pin_oe_in,
  input wire logic [4:0] pin_drive_in,
  input wire logic [4:0] pin_sense_in,
  output logic current_limit_out,
  output logic [4:0] pin_high_drive_out,
  output logic [4:0] pin_slew_out,
  input wire logic leadoff_event_in,
  input wire logic range_event_in,
  input wire logic data_rate_tick_in,
  input wire logic buffer_event_in,
  input wire logic clock_missing_in,
  input wire logic bad_command_in,
  input wire logic [7:0] bad_command_code_in,
  output logic [1:0] irq_pin_out,
  output logic [1:0] irq_pin_oe_out,
  input wire logic frame_miss_in,
  input wire logic fifo_enable_in,
  input wire logic [3:0] fifo_rd_ptr_in,
  input wire logic [3:0] fifo_wr_ptr_in,
  input wire logic cmd_check_error_in,
  input wire logic data_check_error_in,
  input wire logic init_setting_error_in,
  input wire logic [3:0] over_range_in,
  input wire logic [5:0] lead_off_in,
  input wire logic offset_cal_command_in,
  input wire logic sample_valid_in,
  input wire logic [DW-1:0] ch1_raw_in,
  input wire logic [DW-1:0] ch2_raw_in,
  output logic [DW-1:0] ch1_data_out,
  output logic [DW-1:0] ch2_data_out,
  output logic ch_valid_out,
  output logic cal_busy_out
);
  // ==========================================
  // Register bus
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, w_mask_reg, rdata_reg;
  fsi_resp_t bresp_reg, rresp_reg;
  logic do_write;
  logic [31:0] wr_val;
  logic [5:0] io_config_reg, irq_en_reg;
  logic serial_out_drive_sel;
  logic [7:0] status_reg, status_next, status_clr;
  logic [7:0] bad_code_reg;
  logic [DW-1:0] ofc1_reg, ofc2_reg;
  logic buffer_err_reg;
  fsi_cal_state_t cal_state_reg;
  logic [31:0] rd_mux;
  logic rd_ok, wr_ok;

  assign s_axi_awready_out = !aw_held_reg;
  assign s_axi_wready_out = !w_held_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_val = w_data_reg & w_mask_reg;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_in && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_mask_reg <= 32'h0;
    end else if (s_axi_wvalid_in && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_in;
      w_mask_reg <= {{8{s_axi_wstrb_in[3]}}, {8{s_axi_wstrb_in[2]}},
                     {8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_addr_reg)
      `FSI_A_IO_CFG, `FSI_A_MISC_CFG, `FSI_A_IRQ_EN, `FSI_A_STATUS,
      `FSI_A_OFC1, `FSI_A_OFC2: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Merges byte lanes into a register's old value
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~w_mask_reg) | wr_val;
  endfunction : merge

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_config_reg <= `FSI_IO_CFG_RST;
      irq_en_reg <= `FSI_IRQ_EN_RST;
      serial_out_drive_sel <= 1'b0;
    end else if (do_write) begin
      if (aw_addr_reg == `FSI_A_IO_CFG) begin
        io_config_reg <= 6'(merge({26'h0, io_config_reg}));
      end
      if (aw_addr_reg == `FSI_A_IRQ_EN) begin
        irq_en_reg <= 6'(merge({26'h0, irq_en_reg}));
      end
      if (aw_addr_reg == `FSI_A_MISC_CFG) begin
        serial_out_drive_sel <= 1'(merge({31'h0, serial_out_drive_sel}));
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr_in)
      `FSI_A_IO_CFG: rd_mux = {26'h0, io_config_reg};
      `FSI_A_MISC_CFG: rd_mux = {31'h0, serial_out_drive_sel};
      `FSI_A_IRQ_EN: rd_mux = {26'h0, irq_en_reg};
      `FSI_A_STATUS: rd_mux = {21'h0, cal_state_reg == CAL_MEASURE, init_setting_error_in,
                               buffer_err_reg, status_reg}; // R16 R18
      `FSI_A_DIAG: rd_mux = {22'h0, lead_off_in, over_range_in}; // R18 R19
      `FSI_A_BAD_CODE: rd_mux = {24'h0, bad_code_reg};
      `FSI_A_OFC1: rd_mux = {{(32-DW){1'b0}}, ofc1_reg}; // R22
      `FSI_A_OFC2: rd_mux = {{(32-DW){1'b0}}, ofc2_reg}; // R22
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'b00;
    end else if (s_axi_arvalid_in && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================
  // Pin drive and short capture
  logic high_drive_sel, slew_rate_sel;
  logic gnd_hit, supply_hit;
  assign high_drive_sel = io_config_reg[`FSI_IO_HD];
  assign slew_rate_sel = io_config_reg[`FSI_IO_SLEW];
  assign pin_high_drive_out = {{4{high_drive_sel}}, serial_out_drive_sel}; // R4
  assign pin_slew_out = {5{slew_rate_sel}}; // R4
  assign gnd_hit = high_drive_sel && |(pin_oe_in & pin_drive_in & ~pin_sense_in); // R1 R3
  assign supply_hit = high_drive_sel && |(pin_oe_in & ~pin_drive_in & pin_sense_in); // R1 R3
  assign status_clr = (do_write && aw_addr_reg == `FSI_A_STATUS) ? wr_val[7:0] : 8'h00; // R23

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      current_limit_out <= 1'b0;
    end else begin
      current_limit_out <= gnd_hit || supply_hit; // R1
    end
  end

  // Status bits: 0 gnd short, 1 supply short, 2 clock miss, 3 bad command,
  // 4 frame miss, 5 command check, 6 data check; set wins over clear
  always_comb begin
    status_next = status_reg & ~status_clr; // R23
    if (status_next[1:0] == 2'b00) begin
      status_next[0] = gnd_hit; // R2 R3
      status_next[1] = supply_hit; // R2 R3
    end
    status_next[2] = status_next[2] | clock_missing_in; // R14
    status_next[3] = status_next[3] | bad_command_in;
    status_next[4] = status_next[4] | frame_miss_in; // R15
    status_next[5] = status_next[5] | cmd_check_error_in; // R17
    status_next[6] = status_next[6] | data_check_error_in; // R17
    status_next[7] = 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bad_code_reg <= 8'h00;
    end else if (bad_command_in && !status_reg[3]) begin
      bad_code_reg <= bad_command_code_in; // R13
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      buffer_err_reg <= 1'b0;
    end else begin
      buffer_err_reg <= !fifo_enable_in && (fifo_rd_ptr_in != fifo_wr_ptr_in); // R16
    end
  end

  // ==========================================
  // Interrupt sources and pin routing
  logic leadoff_irq, range_irq, buffer_irq, clock_loss_irq, bad_command_irq, irq_any;
  logic [19:0] loff_load;
  logic [1:0] debounce_sel;
  logic irq_pin_select, bad_command_irq_enable;
  assign debounce_sel = irq_en_reg[`FSI_EN_DEB_HI:`FSI_EN_DEB_LO];
  assign irq_pin_select = io_config_reg[`FSI_IO_PINSEL];
  assign bad_command_irq_enable = io_config_reg[`FSI_IO_BADEN];

  always_comb begin
    unique case (debounce_sel)
      2'b10: loff_load = LOFF_LONG_CYC[19:0]; // R8
      2'b01: loff_load = LOFF_SHORT_CYC[19:0]; // R8
      default: loff_load = 20'h00001;
    endcase
  end

  fsi_pulse_stretch #(.CW(20)) u_loff (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .trig_in(leadoff_event_in && irq_en_reg[`FSI_EN_LOFF]), // R9
    .tick_in(1'b1),
    .load_in(loff_load),
    .pulse_out(leadoff_irq)
  );

  fsi_pulse_stretch #(.CW(20)) u_range (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .trig_in(range_event_in && irq_en_reg[`FSI_EN_RANGE]), // R9
    .tick_in(data_rate_tick_in), // R10
    .load_in(20'(`FSI_RANGE_TICKS)),
    .pulse_out(range_irq)
  );

  fsi_pulse_stretch #(.CW(20)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .trig_in(buffer_event_in && irq_en_reg[`FSI_EN_FIFO]), // R9
    .tick_in(1'b1),
    .load_in(20'(`FSI_FIFO_CYC)), // R11
    .pulse_out(buffer_irq)
  );

  assign clock_loss_irq = status_reg[2] && irq_en_reg[`FSI_EN_CLK]; // R12 R9
  assign bad_command_irq = status_reg[3] && bad_command_irq_enable; // R13 R9
  assign irq_any = leadoff_irq || range_irq || buffer_irq || clock_loss_irq || bad_command_irq; // R6

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_pin_out <= 2'b00;
      irq_pin_oe_out <= 2'b00;
    end else begin
      irq_pin_oe_out <= {io_config_reg[`FSI_IO_G2OE], io_config_reg[`FSI_IO_G1OE]}; // R6
      irq_pin_out <= {irq_any && irq_pin_select, irq_any && !irq_pin_select}; // R7
    end
  end

  // ==========================================
  // Offset calibration and correction
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cal_state_reg <= CAL_IDLE;
    end else begin
      unique case (cal_state_reg)
        CAL_IDLE: if (offset_cal_command_in) cal_state_reg <= CAL_MEASURE; // R20
        CAL_MEASURE: if (sample_valid_in) cal_state_reg <= CAL_IDLE;
      endcase
    end
  end
  assign cal_busy_out = (cal_state_reg == CAL_MEASURE);

  // Calibration result wins over a software write in the same cycle
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ofc1_reg <= `FSI_OFC_RST;
      ofc2_reg <= `FSI_OFC_RST;
    end else if (cal_busy_out && sample_valid_in) begin
      ofc1_reg <= ch1_raw_in; // R20
      ofc2_reg <= ch2_raw_in; // R20
    end else if (do_write && aw_addr_reg == `FSI_A_OFC1) begin
      ofc1_reg <= DW'(merge({{(32-DW){1'b0}}, ofc1_reg})); // R22
    end else if (do_write && aw_addr_reg == `FSI_A_OFC2) begin
      ofc2_reg <= DW'(merge({{(32-DW){1'b0}}, ofc2_reg})); // R22
    end
  end

  fsi_offset_sub #(.W(DW)) u_sub1 (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .valid_in(sample_valid_in),
    .raw_in(ch1_raw_in),
    .ofc_in(ofc1_reg), // R21
    .data_out(ch1_data_out),
    .valid_out(ch_valid_out)
  );

  fsi_offset_sub #(.W(DW)) u_sub2 (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .valid_in(sample_valid_in),
    .raw_in(ch2_raw_in),
    .ofc_in(ofc2_reg), // R21
    .data_out(ch2_data_out),
    .valid_out()
  );

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence s_fifo_trig;
    buffer_event_in && irq_en_reg[`FSI_EN_FIFO];
  endsequence
  sequence s_fifo_hold;
    buffer_irq [*8] ##92 buffer_irq;
  endsequence

  a_short_gnd_set: assert property (gnd_hit && status_reg[1:0] == 2'b00 |=> status_reg[0]) // R3
    else $error("ground short not captured");
  a_short_first_only: assert property (status_reg[1:0] != 2'b00 && status_clr[1:0] == 2'b00
    |=> $stable(status_reg[1:0])) // R2
    else $error("short flags changed while held");
  a_limit_mode: assert property (current_limit_out |-> $past(high_drive_sel)) // R1
    else $error("current limit outside high-drive mode");
  a_irq_pin_high: assert property (irq_any && !irq_pin_select |=> irq_pin_out[0] && !irq_pin_out[1]) // R7
    else $error("selected pin not driven high");
  a_fifo_pulse: assert property (s_fifo_trig |=> s_fifo_hold) // R11
    else $error("fifo interrupt shorter than minimum");
  a_clock_hold: assert property (status_reg[2] && !status_clr[2] |=> status_reg[2]) // R12
    else $error("clock missing flag dropped");
  a_bad_first: assert property (status_reg[3] && bad_command_in |=> $stable(bad_code_reg)) // R13
    else $error("bad command code overwritten");
  a_enable_gate: assert property (!irq_en_reg[`FSI_EN_CLK] |-> !clock_loss_irq) // R9
    else $error("disabled source reached pin");
  a_cal_write: assert property (cal_busy_out && sample_valid_in |=> ofc1_reg == $past(ch1_raw_in)) // R20
    else $error("calibration result not stored");
  a_sub_result: assert property (sample_valid_in |=> ch_valid_out
    && ch1_data_out == DW'($past(ch1_raw_in) - $past(ofc1_reg))) // R21
    else $error("correction not subtracted");
  a_clear_drop: assert property (status_reg[3] && status_clr[3] && !bad_command_in
    |=> !bad_command_irq) // R23
    else $error("cleared flag still holds interrupt");
endmodule : fsi_fault_status_unit

// ===== tb/fsi_mcu_model.sv
// Host model timing interrupt pulses
`timescale 1ns/1ns
module fsi_mcu_model (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic irq_in,
  output int width_out,
  output int rises_out
);
  int run;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run <= 0;
      width_out <= 0;
      rises_out <= 0;
    end else if (irq_in) begin
      run <= run + 1;
      if (run == 0) rises_out <= rises_out + 1;
    end else if (run != 0) begin
      width_out <= run;
      run <= 0;
    end
  end
endmodule : fsi_mcu_model

// ===== tb/tb_top.sv
// Self-checking bench for the fault status unit
`timescale 1ns/1ns
`include "fsi_defs.svh"
module tb_top;
  localparam int LL = 40;
  localparam int LS = 20;
  localparam logic [2:0] TBL [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, data_rate_tick_in = 1'b0, psel = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00, bad_command_code_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, seed = 32'h00000014, d, t, o1, o2;
  logic [3:0] s_axi_wstrb_in = 4'hf, fifo_rd_ptr_in = 4'h0, fifo_wr_ptr_in = 4'h0, over_range_in = 4'h0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, fifo_enable_in = 1'b1, init_setting_error_in = 1'b0;
  logic [4:0] pin_oe_in = 5'h00, pin_drive_in = 5'h00, pin_sense_in = 5'h00, pin_high_drive_out, pin_slew_out;
  logic [5:0] lead_off_in = 6'h00;
  logic [23:0] ch1_raw_in = 24'h0, ch2_raw_in = 24'h0, ch1_data_out, ch2_data_out;
  logic [9:0] ev = 10'h000;
  logic [2:0] tcnt = 3'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, irq_pin_out, irq_pin_oe_out, r;
  logic current_limit_out, ch_valid_out, cal_busy_out;
  int failures = 0, samples_checked = 0, width, rises, i, k;
  wire logic leadoff_event_in = ev[0];
  wire logic range_event_in = ev[1];
  wire logic buffer_event_in = ev[2];
  wire logic clock_missing_in = ev[3];
  wire logic bad_command_in = ev[4];
  wire logic frame_miss_in = ev[5];
  wire logic cmd_check_error_in = ev[6];
  wire logic data_check_error_in = ev[7];
  wire logic offset_cal_command_in = ev[8];
  wire logic sample_valid_in = ev[9];
  // Pulled down when undriven
  wire logic irq_line = irq_pin_oe_out[psel] ? irq_pin_out[psel] : 1'b0;

  fsi_fault_status_unit #(.LOFF_LONG_CYC(LL), .LOFF_SHORT_CYC(LS)) DUT (.*);
  fsi_mcu_model mcu (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .irq_in(irq_line), .width_out(width),
    .rises_out(rises));

  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    tcnt <= tcnt + 3'h1;
    data_rate_tick_in <= (tcnt == 3'h7);
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic logic [9:0] exp_drv(input logic [2:0] tb);
    return {{5{tb[2]}}, {4{tb[1]}}, tb[0]};
  endfunction : exp_drv
  function automatic logic [23:0] exp_sub(input logic [23:0] raw, ofc);
    return raw - ofc;
  endfunction : exp_sub
  task automatic results();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_rng(input int g, lo, hi);
    samples_checked++;
    if (g < lo || g > hi) begin
      failures++;
      $display("Error at %0t: width %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask : chk_rng
  task automatic stuck();
    failures++;
    $display("Error at %0t: wait ran out", $time);
    results();
  endtask : stuck
  task automatic wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] wr_r);
    int n;
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= wd;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out) break;
    end
    if (n == 50) stuck();
    wr_r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] rdd, output logic [1:0] rd_r);
    int n;
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out) break;
    end
    if (n == 50) stuck();
    rdd = s_axi_rdata_out;
    rd_r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : rd
  task automatic w(input logic [7:0] a, input logic [31:0] wd);
    wr(a, wd, r);
    chk(r, 2'h0);
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [31:0] e, m);
    rd(a, d, r);
    chk(d & m, e);
  endtask : rc
  task automatic pls(input int b);
    @(posedge clk_sys_in);
    ev[b] <= 1'b1;
    @(posedge clk_sys_in);
    ev[b] <= 1'b0;
  endtask : pls
  task automatic irq_test(input int b, lo, hi);
    int r0, n;
    r0 = rises;
    pls(b);
    for (n = 0; n < 20 && !irq_line; n++) @(posedge clk_sys_in);
    chk(irq_pin_out, psel ? 2'h2 : 2'h1);
    for (n = 0; n < 2000 && irq_line; n++) @(posedge clk_sys_in);
    if (irq_line) stuck();
    repeat (2) @(posedge clk_sys_in);
    chk(rises, r0 + 1);
    chk_rng(width, lo, hi);
  endtask : irq_test

  // ==========================================
  // Scenarios
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rc(`FSI_A_IO_CFG, `FSI_IO_CFG_RST, 32'hffffffff);
    rc(`FSI_A_IRQ_EN, `FSI_IRQ_EN_RST, 32'hffffffff);
    rc(`FSI_A_OFC1, `FSI_OFC_RST, 32'hffffffff);
    rd(8'h20, d, r);
    chk({r, d[29:0]}, {2'h2, 30'h0});
    wr(8'h24, 32'h1, r);
    chk(r, 2'h2);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      w(`FSI_A_IO_CFG, {30'h0, TBL[i][2], TBL[i][1]});
      w(`FSI_A_MISC_CFG, {31'h0, TBL[i][0]});
      chk({pin_slew_out, pin_high_drive_out}, exp_drv(TBL[i]));
    end
    $display("test drive done");
    k = rnd() % 5;
    w(`FSI_A_IO_CFG, 32'h1);
    pin_oe_in <= 5'h01 << k;
    pin_drive_in <= 5'h01 << k;
    repeat (3) @(posedge clk_sys_in);
    chk(current_limit_out, 1'b1);
    rc(`FSI_A_STATUS, 32'h1, 32'h3);
    pin_drive_in <= 5'h00;
    pin_sense_in <= 5'h01 << k;
    repeat (3) @(posedge clk_sys_in);
    rc(`FSI_A_STATUS, 32'h1, 32'h3);
    w(`FSI_A_STATUS, 32'h3);
    rc(`FSI_A_STATUS, 32'h2, 32'h3);
    w(`FSI_A_IO_CFG, 32'h0);
    w(`FSI_A_STATUS, 32'h3);
    repeat (3) @(posedge clk_sys_in);
    chk(current_limit_out, 1'b0);
    rc(`FSI_A_STATUS, 32'h0, 32'h3);
    pin_oe_in <= 5'h00;
    $display("test short done");
    for (i = 0; i < 2; i++) begin
      psel <= i[0];
      w(`FSI_A_IO_CFG, i ? 32'h24 : 32'h10);
      w(`FSI_A_IRQ_EN, 32'h4);
      irq_test(2, `FSI_FIFO_CYC, `FSI_FIFO_CYC);
      chk(irq_pin_oe_out, i ? 2'h2 : 2'h1);
    end
    w(`FSI_A_IRQ_EN, 32'h0);
    k = rises;
    pls(2);
    repeat (10) @(posedge clk_sys_in);
    chk(rises, k);
    w(`FSI_A_IRQ_EN, 32'h21);
    irq_test(0, LL, LL + 3);
    w(`FSI_A_IRQ_EN, 32'h11);
    irq_test(0, LS, LS + 3);
    w(`FSI_A_IRQ_EN, 32'h1);
    irq_test(0, 1, 1);
    w(`FSI_A_IRQ_EN, 32'h2);
    irq_test(1, 8, 18);
    $display("test pulses done");
    w(`FSI_A_IRQ_EN, 32'h8);
    pls(3);
    repeat (20) @(posedge clk_sys_in);
    chk(irq_line, 1'b1);
    rc(`FSI_A_STATUS, 32'h4, 32'h4);
    w(`FSI_A_STATUS, 32'h4);
    repeat (3) @(posedge clk_sys_in);
    chk(irq_line, 1'b0);
    t = rnd();
    w(`FSI_A_IO_CFG, 32'h2c);
    bad_command_code_in <= t[7:0];
    pls(4);
    bad_command_code_in <= ~t[7:0];
    pls(4);
    rc(`FSI_A_BAD_CODE, {24'h0, t[7:0]}, 32'hff);
    chk(irq_line, 1'b1);
    w(`FSI_A_STATUS, 32'h8);
    repeat (3) @(posedge clk_sys_in);
    chk(irq_line, 1'b0);
    $display("test levels done");
    t = rnd();
    over_range_in <= t[3:0];
    lead_off_in <= t[9:4];
    init_setting_error_in <= 1'b1;
    fifo_enable_in <= 1'b0;
    fifo_wr_ptr_in <= 4'h3;
    for (i = 5; i < 8; i++) pls(i);
    repeat (3) @(posedge clk_sys_in);
    rc(`FSI_A_DIAG, {22'h0, t[9:0]}, 32'h3ff);
    rc(`FSI_A_STATUS, 32'h370, 32'h370);
    fifo_enable_in <= 1'b1;
    init_setting_error_in <= 1'b0;
    w(`FSI_A_STATUS, 32'h70);
    rc(`FSI_A_STATUS, 32'h0, 32'h370);
    $display("test diag done");
    for (i = 0; i < 3; i++) begin
      o1 = rnd() & 32'hffffff;
      o2 = rnd() & 32'hffffff;
      w(`FSI_A_OFC1, o1);
      w(`FSI_A_OFC2, o2);
      rc(`FSI_A_OFC2, o2, 32'hffffff);
      t = rnd();
      ch1_raw_in <= t[23:0];
      ch2_raw_in <= ~t[23:0];
      pls(9);
      for (k = 0; k < 4 && ch_valid_out !== 1'b1; k++) @(posedge clk_sys_in);
      chk(ch_valid_out, 1'b1);
      chk(ch1_data_out, exp_sub(t[23:0], o1[23:0]));
      chk(ch2_data_out, exp_sub(~t[23:0], o2[23:0]));
    end
    pls(8);
    @(posedge clk_sys_in);
    chk(cal_busy_out, 1'b1);
    t = rnd();
    ch1_raw_in <= t[23:0];
    ch2_raw_in <= ~t[23:0];
    pls(9);
    repeat (3) @(posedge clk_sys_in);
    chk(cal_busy_out, 1'b0);
    rc(`FSI_A_OFC1, {8'h0, t[23:0]}, 32'hffffff);
    rc(`FSI_A_OFC2, {8'h0, ~t[23:0]}, 32'hffffff);
    $display("test offset done");
    results();
  end
endmodule : tb_top
